// [common/cbs_defs.svh]
// Offsets, field positions and reset values of the card bridge
// control registers. Assumes inclusion by bare name.
`ifndef CBS_DEFS_SVH
`define CBS_DEFS_SVH
`define CBS_NUM_SOCK 2
`define CBS_NUM_TERM 7
`define CBS_OFF_SYSCTL 8'h80
`define CBS_OFF_ROUTE 8'h8C
`define CBS_BIT_PROBE 8
`define CBS_BIT_RSVD7 7
`define CBS_BIT_PWRSAVE 6
`define CBS_BIT_LOCK 5
`define CBS_BIT_PARSERR 4
`define CBS_BIT_CDMA 3
`define CBS_BIT_SUPPLY 2
`define CBS_BIT_VETO 1
`define CBS_BIT_RING_WAKE_MUX_SEL 0
`define CBS_LOCK_RST 1'b1
`define CBS_ROUTE_RST 32'h00000000
`define CBS_ROUTE_RW_MASK 32'h0FFFFFFF
`define CBS_DMA_CODE 4'hE
`endif

// [common/cbs_pkg.sv]
// Types shared by the card bridge control register bank.
// Assumes cbs_defs.svh is on the include path.
`include "cbs_defs.svh"
package cbs_pkg;
  typedef logic [31:0] cbs_word_t;
  typedef logic [`CBS_NUM_SOCK-1:0] cbs_sock_t;

  typedef struct packed {
    logic pwrSave;
    logic supply5v;
    logic ringMux;
    logic gateClk;
  } cbs_sock_s;

  typedef struct packed {
    cbs_word_t route;
    logic lock;
    logic parSerr;
    logic cdmaEn;
    logic veto;
    cbs_word_t rdData;
    logic ack;
    logic serr;
    logic dmaActive;
    logic pciStopGnt;
    cbs_sock_t cbStopGnt;
    logic riPme;
  } cbs_top_s;
endpackage : cbs_pkg

// [common/cbs_sock_if.sv]
// Per-socket link between the register bank and one socket slice.
// Assumes one instance per configuration function.
`timescale 1ns/1ns
interface cbs_sock_if;
  logic wrEn;
  logic [7:0] wrData;
  logic pwrSave;
  logic supply5v;
  logic ringMux;
  logic gateClk;
  modport bank (output wrEn, output wrData, input pwrSave,
    input supply5v, input ringMux, input gateClk);
  modport sock (input wrEn, input wrData, output pwrSave,
    output supply5v, output ringMux, output gateClk);
endinterface : cbs_sock_if

// [verilog/cbs_sock_ctl.sv]
// Per-socket control bits and CardBus state machine clock gate.
// Assumes card status inputs come from logic on clk.
`timescale 1ns/1ns
`include "cbs_defs.svh"
module cbs_sock_ctl
  import cbs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  cbs_sock_if.sock bus,
  input wire logic cardInserted,
  input wire logic cardIdle,
  input wire logic cardClkStopped
);
  cbs_sock_s st_ff;
  cbs_sock_s nxt_st;

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st = st_ff;
    if (bus.wrEn) begin
      nxt_st.pwrSave = bus.wrData[`CBS_BIT_PWRSAVE];
      nxt_st.supply5v = bus.wrData[`CBS_BIT_SUPPLY];
      nxt_st.ringMux = bus.wrData[`CBS_BIT_RING_WAKE_MUX_SEL];
    end
    nxt_st.gateClk = nxt_st.pwrSave & cardInserted & cardIdle &
      cardClkStopped;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bus.pwrSave = st_ff.pwrSave;
  assign bus.supply5v = st_ff.supply5v;
  assign bus.ringMux = st_ff.ringMux;
  assign bus.gateClk = st_ff.gateClk;

  ////////////////////////////////////////////////////////////////////
  // Checks
  chk_gate_idle_card: assert property (
    @(posedge clk) disable iff (!rst_n)
    (st_ff.pwrSave && cardInserted && cardIdle && cardClkStopped &&
      !bus.wrEn) |=> st_ff.gateClk)
    else $error("clock not gated for idle card");
  chk_gate_off_busy: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!cardIdle || !cardInserted) |=> !st_ff.gateClk)
    else $error("clock gated for busy card");
  chk_supply_write: assert property (
    @(posedge clk) disable iff (!rst_n)
    bus.wrEn |=> st_ff.supply5v == $past(bus.wrData[`CBS_BIT_SUPPLY]))
    else $error("supply select not written");
  cov_gate: cover property (@(posedge clk) st_ff.gateClk);
endmodule : cbs_sock_ctl

// [verilog/cbs_sysctl_regs.sv]
// System control low bits and multifunction routing register bank.
// Assumes a one-cycle config request port and same-clock inputs.
//
// Function
// - Per-socket read-only probe busy bit, reset 0
// - Bit 7 of system control reads zero
// - Gate idle stopped card state machine clock
// - Shared write lock guards ident registers, reset 1
// - Card parity reaches system error only if enabled
// - Central DMA needs enable bit and routing
// - Supply select bit: 0 3.3 V, 1 5 V
// - Veto bit refuses all clock stop requests
// - Mux 0: ring and wake share, ring wins
// - Mux 1 in both sockets: only wake drives the terminal
// - Global bits exist once, reached via function 0
// - Seven terminals default to general purpose input
// - Routing register at 0x8C, resets all zeros
// - Routing default loadable from serial EEPROM
// - Routing bits 31 to 28 read zero
`timescale 1ns/1ns
`include "cbs_defs.svh"
module cbs_sysctl_regs
  import cbs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cfgReq,
  input wire logic cfgWr,
  input wire logic cfgFunc,
  input wire logic [7:0] cfgOffset,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWrData,
  output logic cfgAck,
  output logic [31:0] cfgRdData,
  input wire logic romLoadValid,
  input wire logic [31:0] romLoadData,
  input wire logic [`CBS_NUM_SOCK-1:0] probeBusy,
  input wire logic [`CBS_NUM_SOCK-1:0] cardInserted,
  input wire logic [`CBS_NUM_SOCK-1:0] cardIdle,
  input wire logic [`CBS_NUM_SOCK-1:0] cardClkStopped,
  input wire logic [`CBS_NUM_SOCK-1:0] cardParityErr,
  input wire logic pciClkStopReq,
  input wire logic [`CBS_NUM_SOCK-1:0] cbClkStopReq,
  input wire logic [`CBS_NUM_SOCK-1:0] ringAssert,
  input wire logic pmeAssert,
  output logic [`CBS_NUM_SOCK-1:0] cbClkGate,
  output logic [`CBS_NUM_SOCK-1:0] supply5v,
  output logic identWriteLock,
  output logic sysErrReq,
  output logic centralDmaActive,
  output logic pciClkStopGnt,
  output logic [`CBS_NUM_SOCK-1:0] cbClkStopGnt,
  output logic riPmeOut,
  output logic [27:0] termRouting
);
  localparam int NS = `CBS_NUM_SOCK;
  localparam int NT = `CBS_NUM_TERM;

  cbs_top_s st_ff;
  cbs_top_s nxt_st;
  logic wrSys;
  logic wrRoute;
  logic rdSys;
  logic rdRoute;
  logic [NT-1:0] termIsDma;
  logic [NS-1:0] sockPwrSave;
  logic [NS-1:0] sockSupply;
  logic [NS-1:0] sockRingMux;
  logic [NS-1:0] sockGate;
  logic [31:0] sysWord;

  ////////////////////////////////////////////////////////////////////
  // Socket slices, one per function
  for (genvar s = 0; s < NS; s++) begin : g_sock
    cbs_sock_if sif ();
    assign sif.wrEn = wrSys && cfgByteEn[0] && (cfgFunc == 1'(s));
    assign sif.wrData = cfgWrData[7:0];
    assign sockPwrSave[s] = sif.pwrSave;
    assign sockSupply[s] = sif.supply5v;
    assign sockRingMux[s] = sif.ringMux;
    assign sockGate[s] = sif.gateClk;
    cbs_sock_ctl u_sock (
      .clk(clk),
      .rst_n(rst_n),
      .bus(sif),
      .cardInserted(cardInserted[s]),
      .cardIdle(cardIdle[s]),
      .cardClkStopped(cardClkStopped[s])
    );
  end

  // Terminal fields routed for centralized DMA
  for (genvar t = 0; t < NT; t++) begin : g_term
    assign termIsDma[t] = (st_ff.route[4*t +: 4] == `CBS_DMA_CODE);
  end

  ////////////////////////////////////////////////////////////////////
  // Address decode
  always_comb begin
    wrSys = 1'b0;
    wrRoute = 1'b0;
    rdSys = 1'b0;
    rdRoute = 1'b0;
    if (cfgReq && cfgOffset == `CBS_OFF_SYSCTL) begin
      wrSys = cfgWr;
      rdSys = !cfgWr;
    end else if (cfgReq && cfgOffset == `CBS_OFF_ROUTE) begin
      wrRoute = cfgWr;
      rdRoute = !cfgWr;
    end
  end

  // Read view of system control for the addressed function
  always_comb begin
    sysWord = 32'h00000000;
    sysWord[`CBS_BIT_PROBE] = probeBusy[cfgFunc];
    sysWord[`CBS_BIT_RSVD7] = 1'b0;
    sysWord[`CBS_BIT_PWRSAVE] = sockPwrSave[cfgFunc];
    sysWord[`CBS_BIT_SUPPLY] = sockSupply[cfgFunc];
    sysWord[`CBS_BIT_RING_WAKE_MUX_SEL] = sockRingMux[cfgFunc];
    if (!cfgFunc) begin
      sysWord[`CBS_BIT_LOCK] = st_ff.lock;
      sysWord[`CBS_BIT_PARSERR] = st_ff.parSerr;
      sysWord[`CBS_BIT_CDMA] = st_ff.cdmaEn;
      sysWord[`CBS_BIT_VETO] = st_ff.veto;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = cfgReq;
    if (rdSys) begin
      nxt_st.rdData = sysWord;
    end else if (rdRoute) begin
      nxt_st.rdData = st_ff.route;
    end else if (cfgReq) begin
      nxt_st.rdData = 32'h00000000;
    end
    // Global bits only through function 0
    if (wrSys && cfgByteEn[0] && !cfgFunc) begin
      nxt_st.lock = cfgWrData[`CBS_BIT_LOCK];
      nxt_st.parSerr = cfgWrData[`CBS_BIT_PARSERR];
      nxt_st.cdmaEn = cfgWrData[`CBS_BIT_CDMA];
      nxt_st.veto = cfgWrData[`CBS_BIT_VETO];
    end
    if (romLoadValid) begin
      nxt_st.route = romLoadData & `CBS_ROUTE_RW_MASK;
    end else if (wrRoute) begin
      for (int b = 0; b < 4; b++) begin
        if (cfgByteEn[b]) begin
          nxt_st.route[8*b +: 8] = cfgWrData[8*b +: 8];
        end
      end
      nxt_st.route = nxt_st.route & `CBS_ROUTE_RW_MASK;
    end
    nxt_st.serr = st_ff.parSerr && (|cardParityErr);
    nxt_st.dmaActive = st_ff.cdmaEn && (|termIsDma);
    nxt_st.pciStopGnt = pciClkStopReq && !st_ff.veto;
    nxt_st.cbStopGnt = cbClkStopReq & {NS{!st_ff.veto}};
    // Ring wins unless its socket muxes it away
    if (|(ringAssert & ~sockRingMux)) begin
      nxt_st.riPme = 1'b1;
    end else begin
      nxt_st.riPme = pmeAssert;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.lock <= `CBS_LOCK_RST;
      st_ff.route <= `CBS_ROUTE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign cfgAck = st_ff.ack;
  assign cfgRdData = st_ff.rdData;
  assign cbClkGate = sockGate;
  assign supply5v = sockSupply;
  assign identWriteLock = st_ff.lock;
  assign sysErrReq = st_ff.serr;
  assign centralDmaActive = st_ff.dmaActive;
  assign pciClkStopGnt = st_ff.pciStopGnt;
  assign cbClkStopGnt = st_ff.cbStopGnt;
  assign riPmeOut = st_ff.riPme;
  assign termRouting = st_ff.route[27:0];

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_route_top_zero: assert property (
    st_ff.route[31:28] == 4'h0)
    else $error("routing top nibble not zero");
  chk_rsvd_read_zero: assert property (
    rdSys |=> cfgAck && cfgRdData[`CBS_BIT_RSVD7] == 1'b0)
    else $error("reserved bit read nonzero");
  chk_probe_read_live: assert property (
    rdSys |=> cfgRdData[`CBS_BIT_PROBE] ==
      $past(probeBusy[cfgFunc]))
    else $error("probe busy bit misread");
  chk_func1_global: assert property (
    (wrSys && cfgFunc && !romLoadValid) |=>
      $stable(st_ff.lock) && $stable(st_ff.veto))
    else $error("global bit written via function 1");
  chk_lock_write: assert property (
    (wrSys && !cfgFunc && cfgByteEn[0]) |=>
      identWriteLock == $past(cfgWrData[`CBS_BIT_LOCK]))
    else $error("write lock not updated");
  chk_serr_gated: assert property (
    (!st_ff.parSerr && !(wrSys && !cfgFunc)) |=> !sysErrReq)
    else $error("parity reported while disabled");
  chk_serr_report: assert property (
    (st_ff.parSerr && |cardParityErr) |=> sysErrReq)
    else $error("parity error not reported");
  chk_dma_gate: assert property (
    centralDmaActive |-> $past(st_ff.cdmaEn) && $past(|termIsDma))
    else $error("central dma active without routing");
  chk_veto_refuse: assert property (
    st_ff.veto |=> !pciClkStopGnt && cbClkStopGnt == '0)
    else $error("clock stop granted under veto");
  chk_ring_prio: assert property (
    (|(ringAssert & ~sockRingMux)) |=> riPmeOut)
    else $error("ring lost precedence");
  chk_pme_only: assert property (
    (sockRingMux == '1) |=> riPmeOut == $past(pmeAssert))
    else $error("ring leaked onto wake terminal");
  chk_route_load: assert property (
    romLoadValid |=> termRouting == $past(romLoadData[27:0]))
    else $error("eeprom routing not loaded");
  chk_route_reset: assert property (
    $rose(rst_n) |-> termRouting == 28'h0000000)
    else $error("routing not zero after reset");
  chk_lock_reset: assert property (
    $rose(rst_n) |-> identWriteLock)
    else $error("write lock not set after reset");
  chk_route_read: assert property (
    rdRoute |=> cfgRdData == $past(st_ff.route))
    else $error("routing read mismatch");
  chk_route_write: assert property (
    (wrRoute && !romLoadValid && cfgByteEn == 4'hF) |=>
      termRouting == $past(cfgWrData[27:0]))
    else $error("routing write lost");
  chk_route_lane: assert property (
    (wrRoute && !romLoadValid && !cfgByteEn[0]) |=>
      $stable(termRouting[7:0]))
    else $error("disabled byte lane written");
  chk_func1_rd_zero: assert property (
    (rdSys && cfgFunc) |=> !cfgRdData[`CBS_BIT_LOCK] &&
      !cfgRdData[`CBS_BIT_PARSERR] && !cfgRdData[`CBS_BIT_CDMA] &&
      !cfgRdData[`CBS_BIT_VETO])
    else $error("global bit visible via function 1");
  chk_func1_enables: assert property (
    (wrSys && cfgFunc) |=>
      $stable(st_ff.parSerr) && $stable(st_ff.cdmaEn))
    else $error("enable written via function 1");
  chk_sock1_supply: assert property (
    (wrSys && cfgFunc && cfgByteEn[0]) |=>
      sockSupply[1] == $past(cfgWrData[`CBS_BIT_SUPPLY]))
    else $error("socket 1 supply not written");
  chk_sock1_isolate: assert property (
    (wrSys && !cfgFunc) |=> $stable(sockSupply[1]))
    else $error("function 0 reached socket 1");
  chk_sock0_pwrsave: assert property (
    (wrSys && !cfgFunc && cfgByteEn[0]) |=>
      sockPwrSave[0] == $past(cfgWrData[`CBS_BIT_PWRSAVE]))
    else $error("power saving bit not written");
  chk_sock1_ringmux: assert property (
    (wrSys && cfgFunc && cfgByteEn[0]) |=>
      sockRingMux[1] == $past(cfgWrData[`CBS_BIT_RING_WAKE_MUX_SEL]))
    else $error("ring mux bit not written");
  chk_dma_on: assert property (
    (st_ff.cdmaEn && (|termIsDma)) |=> centralDmaActive)
    else $error("central dma not active");
  chk_dma_off: assert property (
    !st_ff.cdmaEn |=> !centralDmaActive)
    else $error("central dma active while disabled");
  chk_pci_grant: assert property (
    !st_ff.veto |=> pciClkStopGnt == $past(pciClkStopReq))
    else $error("pci clock stop not granted");
  chk_cb_grant: assert property (
    !st_ff.veto |=> cbClkStopGnt == $past(cbClkStopReq))
    else $error("card clock stop not granted");
  chk_pme_pass: assert property (
    ((ringAssert & ~sockRingMux) == '0) |=>
      riPmeOut == $past(pmeAssert))
    else $error("wake not passed to terminal");

  cov_veto: cover property (st_ff.veto && pciClkStopReq);
  cov_dma: cover property (centralDmaActive);
  cov_ring_pme: cover property (ringAssert != '0 && pmeAssert);
  cov_rom_load: cover property (romLoadValid ##1 rdRoute);
endmodule : cbs_sysctl_regs

// [tb/testbench.sv]
// Self-checking bench for the card bridge control register bank.
// Assumes the package, interface and design files are compiled first.
`timescale 1ns/1ns
`include "cbs_defs.svh"
module testbench
  import cbs_pkg::*;
;
  logic clk, rst_n, cfgReq, cfgWr, cfgFunc, romLoadValid, pciClkStopReq;
  logic pmeAssert, cfgAck, identWriteLock, sysErrReq, centralDmaActive;
  logic pciClkStopGnt, riPmeOut;
  logic [7:0] cfgOffset;
  logic [3:0] cfgByteEn;
  cbs_word_t cfgWrData, romLoadData, cfgRdData;
  logic [1:0] probeBusy, cardInserted, cardIdle, cardClkStopped;
  logic [1:0] cardParityErr, cbClkStopReq, ringAssert;
  logic [1:0] cbClkGate, supply5v, cbClkStopGnt;
  logic [27:0] termRouting;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;

  cbs_sysctl_regs cbs_sysctl_regs_i (.clk(clk), .rst_n(rst_n),
    .cfgReq(cfgReq), .cfgWr(cfgWr), .cfgFunc(cfgFunc),
    .cfgOffset(cfgOffset), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
    .cfgAck(cfgAck), .cfgRdData(cfgRdData), .romLoadValid(romLoadValid),
    .romLoadData(romLoadData), .probeBusy(probeBusy),
    .cardInserted(cardInserted), .cardIdle(cardIdle),
    .cardClkStopped(cardClkStopped), .cardParityErr(cardParityErr),
    .pciClkStopReq(pciClkStopReq), .cbClkStopReq(cbClkStopReq),
    .ringAssert(ringAssert), .pmeAssert(pmeAssert), .cbClkGate(cbClkGate),
    .supply5v(supply5v), .identWriteLock(identWriteLock),
    .sysErrReq(sysErrReq), .centralDmaActive(centralDmaActive),
    .pciClkStopGnt(pciClkStopGnt), .cbClkStopGnt(cbClkStopGnt),
    .riPmeOut(riPmeOut), .termRouting(termRouting));

  ////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic check(input cbs_word_t got, input cbs_word_t exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic cfg(input logic wr, input logic fn, input logic [7:0] off,
    input logic [3:0] be, input cbs_word_t data);
    cfgReq = 1'b1;
    cfgWr = wr;
    cfgFunc = fn;
    cfgOffset = off;
    cfgByteEn = be;
    cfgWrData = data;
    @(negedge clk);
    cfgReq = 1'b0;
    check(32'(cfgAck), 32'h1);
    @(negedge clk);
    check(32'(cfgAck), 32'h0);
  endtask : cfg

  task automatic wr(input logic fn, input logic [7:0] off,
    input logic [3:0] be, input cbs_word_t data);
    cfg(1'b1, fn, off, be, data);
  endtask : wr

  task automatic rd(input logic fn, input logic [7:0] off,
    input cbs_word_t exp);
    cfg(1'b0, fn, off, 4'hF, 32'h0);
    check(cfgRdData, exp);
  endtask : rd

  task automatic settle;
    repeat (2) @(negedge clk);
  endtask : settle

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////
  // Clock and timeout
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      n_mismatch++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    {rst_n, cfgReq, cfgWr, cfgFunc, romLoadValid, pciClkStopReq} = 6'h00;
    {pmeAssert, cfgOffset, cfgByteEn, cfgWrData, romLoadData} = 77'h0;
    {probeBusy, cardInserted, cardIdle, cardClkStopped} = 8'h00;
    {cardParityErr, cbClkStopReq, ringAssert} = 6'h00;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    check(32'(identWriteLock), 32'h1);
    check(32'(termRouting), 32'h0);
    rd(1'b0, 8'h80, 32'h20);
    rd(1'b1, 8'h80, 32'h0);
    rd(1'b0, 8'h8C, 32'h0);
    rd(1'b1, 8'h8C, 32'h0);
    rd(1'b0, 8'h40, 32'h0);
    $display("reset test done");
    wr(1'b0, 8'h80, 4'h1, 32'hFFFFFFFF);
    rd(1'b0, 8'h80, 32'h7F);
    wr(1'b1, 8'h80, 4'h1, 32'hFFFFFFFF);
    rd(1'b1, 8'h80, 32'h45);
    rd(1'b0, 8'h80, 32'h7F);
    check(32'(supply5v), 32'h3);
    wr(1'b0, 8'h80, 4'h1, 32'h5F);
    check(32'(identWriteLock), 32'h0);
    wr(1'b1, 8'h80, 4'h1, 32'h41);
    check(32'(supply5v), 32'h1);
    probeBusy = 2'b10;
    settle();
    rd(1'b1, 8'h80, 32'h141);
    rd(1'b0, 8'h80, 32'h5F);
    probeBusy = 2'b00;
    settle();
    rd(1'b1, 8'h80, 32'h41);
    $display("system control test done");
    {cardInserted, cardIdle, cardClkStopped} = 6'h3F;
    settle();
    check(32'(cbClkGate), 32'h3);
    cardIdle = 2'b01;
    settle();
    check(32'(cbClkGate), 32'h1);
    wr(1'b0, 8'h80, 4'h1, 32'h1F);
    cardIdle = 2'b11;
    settle();
    check(32'(cbClkGate), 32'h2);
    $display("clock gate test done");
    pciClkStopReq = 1'b1;
    cbClkStopReq = 2'b11;
    settle();
    check(32'({pciClkStopGnt, cbClkStopGnt}), 32'h0);
    wr(1'b0, 8'h80, 4'h1, 32'h1D);
    check(32'({pciClkStopGnt, cbClkStopGnt}), 32'h7);
    $display("clock veto test done");
    cardParityErr = 2'b01;
    settle();
    check(32'(sysErrReq), 32'h1);
    wr(1'b0, 8'h80, 4'h1, 32'h0D);
    check(32'(sysErrReq), 32'h0);
    cardParityErr = 2'b00;
    $display("parity test done");
    wr(1'b0, 8'h8C, 4'hF, 32'hFFFFFFFF);
    rd(1'b1, 8'h8C, 32'h0FFFFFFF);
    check(32'(termRouting), 32'h0FFFFFFF);
    wr(1'b1, 8'h8C, 4'h2, 32'h0);
    rd(1'b0, 8'h8C, 32'h0FFF00FF);
    wr(1'b0, 8'h8C, 4'hF, 32'h0EEEEEEE);
    check(32'(centralDmaActive), 32'h1);
    wr(1'b0, 8'h80, 4'h1, 32'h05);
    check(32'(centralDmaActive), 32'h0);
    wr(1'b0, 8'h80, 4'h1, 32'h0D);
    wr(1'b0, 8'h8C, 4'hF, 32'h0);
    check(32'(centralDmaActive), 32'h0);
    $display("routing test done");
    ringAssert = 2'b11;
    pmeAssert = 1'b1;
    settle();
    check(32'(riPmeOut), 32'h1);
    pmeAssert = 1'b0;
    settle();
    check(32'(riPmeOut), 32'h0);
    wr(1'b1, 8'h80, 4'h1, 32'h40);
    check(32'(riPmeOut), 32'h1);
    ringAssert = 2'b00;
    pmeAssert = 1'b1;
    settle();
    check(32'(riPmeOut), 32'h1);
    $display("ring wake test done");
    romLoadData = 32'hF1234567;
    romLoadValid = 1'b1;
    @(negedge clk);
    romLoadValid = 1'b0;
    @(negedge clk);
    check(32'(termRouting), 32'h01234567);
    rd(1'b0, 8'h8C, 32'h01234567);
    rst_n = 1'b0;
    settle();
    check(32'({identWriteLock, termRouting}), 32'h10000000);
    rst_n = 1'b1;
    rd(1'b0, 8'h80, 32'h20);
    check(32'(supply5v), 32'h0);
    $display("load and reset test done");
    finish_test();
  end
endmodule : testbench
